//--- design/tape_status_consts.svh
// constants for the tape controller status and interrupt block
// assumes inclusion by bare name from the package and design files
`ifndef TAPE_STATUS_CONSTS_SVH
`define TAPE_STATUS_CONSTS_SVH

// director codes on the q word
`define DIR_STATUS1      2'b01
`define DIR_STATUS2      2'b10
// q word field positions
`define Q_DIR_LSB        0
`define Q_EQUIP_LSB      7
`define Q_EQUIP_MSB      10
`define Q_W_LSB          11
`define Q_W_MSB          12
// first status word bit positions
`define S1_READY         0
`define S1_BUSY          1
`define S1_INT           2
`define S1_DATA          3
`define S1_EOP           4
`define S1_ALARM         5
`define S1_LOST          6
`define S1_PROT          7
`define S1_PARITY        8
`define S1_EOT           9
`define S1_LOADPT        10
`define S1_FMARK         11
`define S1_ACTIVE        12
`define S1_FILL          13
`define S1_STPAR         14
`define S1_PFAULT        15
// second status word bit positions
`define S2_D556          0
`define S2_D800          1
`define S2_D1600         2
`define S2_SEVEN         3
`define S2_WREN          4
`define S2_PEWARN        5
`define S2_PELOST        6
`define S2_PETRAN        7
`define S2_IDABORT       8
`define S2_LOWTH         9
// reset value of the reply register
`define REPLY_RESET      16'h0000
// number of transports
`define NUM_TRANSPORTS   4
// longest legal postamble in zero frames
`define POSTAMBLE_ZEROS  48

`endif

//--- design/tape_status_pkg.sv
// types shared by the tape controller status logic
// assumes the constants header is on the include path
`include "tape_status_consts.svh"

package tape_status_pkg;

  // per transport jumper settings
  typedef struct packed {
    logic protect;
    logic high_speed;
    logic nine_track;
    logic pe_only;
  } jumper_t;

  typedef logic [15:0] word_t;

  // sticky flag set
  typedef struct packed {
    logic data;
    logic eop;
    logic alarm;
    logic lost;
    logic parity;
    logic end_of_tape_flag;
    logic fmark;
    logic fill;
    logic stpar;
    logic pfault;
    logic pewarn;
    logic pelost;
    logic idabort;
    logic int_data;
    logic int_eop;
    logic int_alarm;
  } flags_t;

endpackage

//--- design/sticky_flag.sv
// one sticky status flag: set beats clear
// assumes set and clear are single cycle synchronous strobes
`timescale 1ns/10ps

module sticky_flag (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic reset,
  // events
  input  wire logic set_evt,
  input  wire logic clr_evt,
  // state
  output logic      flag_q
);

  typedef struct packed {
    logic f;
  } st_t;

  st_t s_q;
  st_t s_d;

  // next state: a set in the clearing cycle wins
  always_comb begin
    s_d = s_q;
    if (clr_evt) begin
      s_d.f = 1'b0;
    end
    if (set_evt) begin
      s_d.f = 1'b1;
    end
  end

  // state register
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign flag_q = s_q.f;

endmodule

//--- design/jumper_decode.sv
// selects the jumper group of the addressed transport
// assumes jumpers are static straps sampled synchronously
`timescale 1ns/10ps

module jumper_decode #(
  parameter int NUM = 4
) (
  // clock and reset
  input  wire logic                          clk_sys,
  input  wire logic                          reset,
  // straps of all transports, four bits each
  input  wire logic [NUM*4-1:0]              jumpers,
  input  wire logic [$clog2(NUM)-1:0]        unit_sel,
  // chosen transport
  output logic                               protect_q,
  output logic                               high_speed_q,
  output logic                               nine_track_q,
  output logic                               pe_only_q
);

  typedef struct packed {
    logic [3:0] j;
  } st_t;

  st_t s_q;
  st_t s_d;

  // pick the four straps of the selected unit
  always_comb begin
    s_d = s_q;
    s_d.j = jumpers[unit_sel*4 +: 4];
  end

  // registered selection
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // bit 3 protect, 2 speed, 1 nine track, 0 pe only
  assign protect_q    = s_q.j[3];
  assign high_speed_q = s_q.j[2];
  assign nine_track_q = s_q.j[1];
  assign pe_only_q    = s_q.j[0];

endmodule

//--- design/tape_ctrl_status_interrupt.sv
// status words, sticky flags and interrupt clearing of the tape controller
// assumes a host q/a channel with one-cycle strobes and sync event pulses
`timescale 1ns/10ps
`include "tape_status_consts.svh"

module tape_ctrl_status_interrupt
  import tape_status_pkg::*;
#(
  parameter int NUM = `NUM_TRANSPORTS
) (
  // clock and reset
  input  wire logic                     clk_sys,
  input  wire logic                     reset,
  // host q/a channel
  input  wire logic [12:0]              q_word,
  input  wire logic                     input_req,
  input  wire logic                     output_req,
  input  wire logic                     protected_instr,
  output tape_status_pkg::word_t        a_reply_q,
  output logic                          reply_q,
  output logic                          reject_q,
  // controller commands, one-cycle pulses; int_select, unit_num and buffered_output are levels
  input  wire logic                     master_clear,
  input  wire logic                     clear_controller,
  input  wire logic                     new_motion,
  input  wire logic                     clear_interrupt,
  input  wire logic [2:0]               int_select,
  input  wire logic                     int_select_strobe,
  input  wire logic                     unit_select,
  input  wire logic [1:0]               unit_num,
  input  wire logic                     buffered_input_start,
  input  wire logic                     buffered_output,
  // transport and motion state, levels
  input  wire logic                     ready,
  input  wire logic                     in_motion,
  input  wire logic                     ctrl_active,
  input  wire logic                     load_point,
  input  wire logic                     write_enable,
  input  wire logic                     pe_formatter_in,
  input  wire logic [2:0]               density_sel,
  input  wire logic                     low_threshold,
  // events, one-cycle pulses; xfer_reg_full is a level
  input  wire logic                     motion_done,
  input  wire logic                     data_ready,
  input  wire logic                     data_request,
  input  wire logic                     end_of_record,
  input  wire logic                     new_frame,
  input  wire logic                     xfer_reg_full,
  input  wire logic                     dsa_overrun,
  input  wire logic                     parity_evt,
  input  wire logic                     eot_sensed,
  input  wire logic                     fmark_sensed,
  input  wire logic                     wrong_mode,
  input  wire logic                     odd_words,
  input  wire logic                     host_parity_err,
  input  wire logic                     host_protect_fault,
  input  wire logic                     corrected_dropout,
  input  wire logic                     bad_postamble,
  input  wire logic                     pe_hard_error,
  input  wire logic                     id_burst_seen,
  input  wire logic                     motion_from_loadpt,
  // straps
  input  wire logic [3:0]               equip_jumpers,
  input  wire logic [NUM*4-1:0]         unit_jumpers,
  // outputs to motion logic and host
  output logic                          stop_motion_q,
  output logic                          end_record_q,
  output logic                          stop_input_q,
  output logic                          protect_to_host_q,
  output logic                          interrupt_q,
  output logic                          high_speed_q,
  output logic                          pe_only_q
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    word_t      reply;
    logic       reply_v;
    logic       reject;
    logic       busy;
    logic [2:0] int_en;
    logic       id_pending;
    logic       id_checked;
    logic       stop;
    logic       eor;
    logic       stop_in;
    logic       prot_host;
    logic       buf_in;
    logic       intr;
  } st_t;

  st_t s_q;
  st_t s_d;

  ////////////////////////////////////////////////////////////////////////////
  // strap decode and flags

  logic j_prot;
  logic j_speed;
  logic j_nine;
  logic j_pe;

  jumper_decode #(
    .NUM (NUM)
  ) u_jumpers (
    .clk_sys      (clk_sys),
    .reset        (reset),
    .jumpers      (unit_jumpers),
    .unit_sel     (unit_num[$clog2(NUM)-1:0]),
    .protect_q    (j_prot),
    .high_speed_q (j_speed),
    .nine_track_q (j_nine),
    .pe_only_q    (j_pe)
  );

  logic   clr_motion;
  logic   addressed;
  logic   lost_ac;
  logic   id_fail;
  logic   alarm_evt;
  logic   alarm_live;
  flags_t set_v;
  flags_t clr_v;
  flags_t f;

  // addressed when equipment field matches and w is zero
  assign addressed = (q_word[`Q_EQUIP_MSB:`Q_EQUIP_LSB] == equip_jumpers)
                     && (q_word[`Q_W_MSB:`Q_W_LSB] == 2'b00);
  assign clr_motion = new_motion | master_clear;
  assign lost_ac = new_frame & xfer_reg_full;
  assign id_fail = s_q.id_pending & motion_done;
  assign alarm_evt = eot_sensed | parity_evt | fmark_sensed | wrong_mode
                   | lost_ac | dsa_overrun | host_parity_err
                   | host_protect_fault | id_fail | pe_hard_error
                   | corrected_dropout | bad_postamble
                   | (s_q.busy & ~ready);
  assign alarm_live = ~ready | f.end_of_tape_flag;

  // set and clear conditions of each sticky flag
  always_comb begin
    set_v = '0;
    clr_v = '0;
    set_v.data   = data_ready;
    clr_v.data   = data_request | lost_ac | dsa_overrun | end_of_record
                 | clr_motion | clear_controller;
    set_v.eop    = motion_done;
    clr_v.eop    = clr_motion;
    set_v.alarm  = alarm_evt;
    clr_v.alarm  = clr_motion | clear_controller;
    set_v.lost   = lost_ac | dsa_overrun;
    clr_v.lost   = clr_motion;
    set_v.parity = parity_evt | fmark_sensed | wrong_mode;
    clr_v.parity = clr_motion | clear_controller;
    set_v.end_of_tape_flag    = eot_sensed;
    clr_v.end_of_tape_flag    = clr_motion;
    set_v.fmark  = fmark_sensed;
    clr_v.fmark  = clr_motion;
    set_v.fill   = odd_words;
    clr_v.fill   = clr_motion;
    set_v.stpar  = host_parity_err;
    clr_v.stpar  = clr_motion;
    set_v.pfault = host_protect_fault;
    clr_v.pfault = clr_motion;
    set_v.pewarn = corrected_dropout | bad_postamble;
    clr_v.pewarn = clr_motion;
    set_v.pelost = pe_hard_error;
    clr_v.pelost = clr_motion;
    set_v.idabort = id_fail;
    clr_v.idabort = clr_motion;
    // interrupts: data, end of operation, alarm
    set_v.int_data  = data_ready & s_q.int_en[0];
    clr_v.int_data  = clear_interrupt | clear_controller | unit_select
                    | (int_select_strobe & int_select[0])
                    | data_request | lost_ac | master_clear;
    set_v.int_eop   = motion_done & s_q.int_en[1];
    clr_v.int_eop   = clear_interrupt | clear_controller | unit_select
                    | (int_select_strobe & int_select[1]) | master_clear;
    set_v.int_alarm = alarm_evt & s_q.int_en[2];
    clr_v.int_alarm = clear_interrupt | clear_controller | unit_select
                    | (int_select_strobe & int_select[2] & ~alarm_live)
                    | master_clear;
  end

  // one sticky cell per flag
  for (genvar i = 0; i < $bits(flags_t); i++) begin : g_flags
    sticky_flag u_flag (
      .clk_sys (clk_sys),
      .reset   (reset),
      .set_evt (set_v[i]),
      .clr_evt (clr_v[i]),
      .flag_q  (f[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // status words

  word_t w1;
  word_t w2;

  // word assembly; reading has no side effect on flags
  always_comb begin
    w1 = '0;
    w1[`S1_READY]   = ready;
    w1[`S1_BUSY]    = s_q.busy;
    w1[`S1_INT]     = s_q.intr;
    w1[`S1_DATA]    = f.data;
    w1[`S1_EOP]     = f.eop;
    w1[`S1_ALARM]   = f.alarm;
    w1[`S1_LOST]    = f.lost;
    w1[`S1_PROT]    = j_prot;
    w1[`S1_PARITY]  = f.parity;
    w1[`S1_EOT]     = f.end_of_tape_flag;
    w1[`S1_LOADPT]  = load_point;
    w1[`S1_FMARK]   = f.fmark;
    w1[`S1_ACTIVE]  = ctrl_active;
    w1[`S1_FILL]    = f.fill;
    w1[`S1_STPAR]   = f.stpar;
    w1[`S1_PFAULT]  = f.pfault;
    w2 = '0;
    w2[`S2_D556]    = density_sel[0];
    w2[`S2_D800]    = density_sel[1];
    w2[`S2_D1600]   = density_sel[2];
    w2[`S2_SEVEN]   = ~j_nine;
    w2[`S2_WREN]    = write_enable;
    w2[`S2_PEWARN]  = f.pewarn;
    w2[`S2_PELOST]  = f.pelost;
    w2[`S2_PETRAN]  = j_nine & pe_formatter_in;
    w2[`S2_IDABORT] = f.idabort;
    w2[`S2_LOWTH]   = low_threshold;
  end

  ////////////////////////////////////////////////////////////////////////////
  // control

  logic req;
  logic prot_ok;
  logic is_status;

  assign req       = input_req | output_req;
  assign is_status = input_req && (q_word[1:0] == `DIR_STATUS1
                                   || q_word[1:0] == `DIR_STATUS2);
  assign prot_ok   = ~j_prot | protected_instr | is_status;

  // reply, busy, interrupt selection and id burst tracking
  always_comb begin
    s_d = s_q;
    s_d.reply_v = 1'b0;
    s_d.reject  = 1'b0;
    s_d.stop    = 1'b0;
    s_d.eor     = 1'b0;
    s_d.stop_in = 1'b0;
    if (req && addressed) begin
      if (prot_ok) begin
        s_d.reply_v = 1'b1;
        if (is_status) begin
          s_d.reply = (q_word[1:0] == `DIR_STATUS1) ? w1 : w2;
        end
      end else begin
        s_d.reject = 1'b1;
      end
    end
    // busy rises in the accept cycle, with the reply register
    s_d.busy = in_motion | (new_motion & prot_ok);
    if (int_select_strobe) begin
      s_d.int_en = int_select;
    end
    if (clear_interrupt | clear_controller | master_clear) begin
      s_d.int_en = 3'b000;
    end
    // identification burst watch after leaving load point
    if (motion_from_loadpt && density_sel[2] && !s_q.id_checked) begin
      s_d.id_pending = 1'b1;
    end
    if (id_burst_seen) begin
      s_d.id_pending = 1'b0;
    end
    if (id_fail) begin
      s_d.id_pending = 1'b0;
      s_d.id_checked = 1'b1;
      s_d.stop       = 1'b1;
    end
    if (master_clear | unit_select) begin
      s_d.id_checked = 1'b0;
    end
    if (dsa_overrun) begin
      s_d.eor     = buffered_output;
      s_d.stop_in = ~buffered_output;
    end
    if (buffered_input_start) begin
      s_d.buf_in    = 1'b1;
      s_d.prot_host = protected_instr;
    end
    if (clr_motion & ~buffered_input_start) begin
      s_d.buf_in    = 1'b0;
      s_d.prot_host = 1'b0;
    end
    s_d.intr = f.int_data | f.int_eop | f.int_alarm;
  end

  // state register
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign a_reply_q         = s_q.reply;
  assign reply_q           = s_q.reply_v;
  assign reject_q          = s_q.reject;
  assign stop_motion_q     = s_q.stop;
  assign end_record_q      = s_q.eor;
  assign stop_input_q      = s_q.stop_in;
  assign protect_to_host_q = s_q.prot_host;
  assign interrupt_q       = s_q.intr;
  assign high_speed_q      = j_speed;
  assign pe_only_q         = j_pe;

endmodule

//--- verification/tape_status_chk.sv
// assertion checker for the tape status block, watching its top ports
// assumes requests and events change away from the rising clock edge
`timescale 1ns/10ps

module tape_status_chk #(
  parameter int NUM = 4
) (
  // clock and reset
  input wire logic             clk_sys,
  input wire logic             reset,
  // host channel
  input wire logic [12:0]      q_word,
  input wire logic             input_req,
  input wire logic             output_req,
  input wire logic             protected_instr,
  input wire logic [15:0]      a_reply_q,
  input wire logic             reply_q,
  input wire logic             reject_q,
  // commands and events
  input wire logic             master_clear,
  input wire logic             clear_controller,
  input wire logic             new_motion,
  input wire logic             motion_done,
  input wire logic             parity_evt,
  input wire logic             eot_sensed,
  input wire logic             fmark_sensed,
  // straps and outputs
  input wire logic [1:0]       unit_num,
  input wire logic [3:0]       equip_jumpers,
  input wire logic [NUM*4-1:0] unit_jumpers,
  input wire logic             stop_motion_q,
  input wire logic             interrupt_q
);
  logic hit, rd1, rd2, sprot, quiet;

  // decode of requests aimed at this equipment
  assign hit   = (input_req | output_req) && q_word[12:11] == 2'b00
                 && q_word[10:7] == equip_jumpers;
  assign rd1   = hit && input_req && q_word[1:0] == 2'b01;
  assign rd2   = hit && input_req && q_word[1:0] == 2'b10;
  assign sprot = unit_jumpers[{unit_num, 2'b11}];
  assign quiet = !(new_motion | clear_controller | master_clear);

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  ////////////////////////////////////////
  property p_answer; hit |=> reply_q || reject_q; endproperty
  a_answer: assert property (p_answer) else $error("no answer");
  property p_silent; (input_req || output_req) && !hit |=> !reply_q && !reject_q; endproperty
  a_silent: assert property (p_silent) else $error("answer to stranger");
  property p_status; rd1 || rd2 |=> reply_q && !reject_q; endproperty
  a_status: assert property (p_status) else $error("status refused");
  property p_hi_zero; rd2 |=> a_reply_q[15:10] == 6'h00; endproperty
  a_hi_zero: assert property (p_hi_zero) else $error("word two high bits");
  property p_prot;
    rd1 && $stable(unit_num) && !$past(reset) |=> a_reply_q[7] == $past(sprot);
  endproperty
  a_prot: assert property (p_prot) else $error("protected bit");
  property p_reject;
    hit && output_req && !protected_instr && sprot && $stable(unit_num) && !$past(reset)
      |=> reject_q && !reply_q;
  endproperty
  a_reject: assert property (p_reject) else $error("unprotected accepted");
  sequence s_err; (parity_evt | eot_sensed | fmark_sensed) && quiet; endsequence
  property p_alarm; s_err ##1 rd1 && quiet |=> a_reply_q[5]; endproperty
  a_alarm: assert property (p_alarm) else $error("alarm missing");
  property p_stop; $rose(stop_motion_q) |-> $past(motion_done) || $past(motion_done, 2); endproperty
  a_stop: assert property (p_stop) else $error("stray stop");

  // main scenarios seen
  c_reject: cover property (reject_q);
  c_alarm: cover property (rd1 ##1 a_reply_q[5]);
  c_int: cover property (interrupt_q);
endmodule

bind tape_ctrl_status_interrupt tape_status_chk #(.NUM(NUM)) u_chk (
  .clk_sys, .reset, .q_word, .input_req, .output_req, .protected_instr, .a_reply_q,
  .reply_q, .reject_q, .master_clear, .clear_controller, .new_motion, .motion_done,
  .parity_evt, .eot_sensed, .fmark_sensed, .unit_num, .equip_jumpers, .unit_jumpers,
  .stop_motion_q, .interrupt_q
);

//--- verification/host_model.sv
// host processor model on the q/a request channel
// assumes its task is entered on a falling edge of clk_sys
`timescale 1ns/10ps

module host_model
  import tape_status_pkg::*;
(
  // clock
  input  wire logic                   clk_sys,
  // request side
  output logic [12:0]                 q_word,
  output logic                        input_req,
  output logic                        output_req,
  output logic                        protected_instr,
  // answer side
  input  wire tape_status_pkg::word_t a_reply_q,
  input  wire logic                   reply_q,
  input  wire logic                   reject_q
);
  // idle channel
  initial begin
    q_word = 13'h1_fff;
    input_req = 1'b0;
    output_req = 1'b0;
    protected_instr = 1'b0;
  end

  // one request held over one taken edge, then a bounded wait for the answer
  task automatic xfer(input logic out, input logic [1:0] w, input logic [3:0] eq,
                      input logic [1:0] dir, input logic prot,
                      output word_t d, output logic [1:0] rsp);
    rsp = 2'b00;
    d = '0;
    q_word <= {w, eq, 5'h00, dir};
    input_req <= !out;
    output_req <= out;
    protected_instr <= prot;
    @(negedge clk_sys);
    input_req <= 1'b0;
    output_req <= 1'b0;
    protected_instr <= 1'b0;
    q_word <= ~q_word;
    for (int i = 0; i < 3 && rsp == 2'b00; i++) begin
      if (reply_q === 1'b1 || reject_q === 1'b1) begin
        rsp = {reject_q, reply_q};
        d = a_reply_q;
      end else begin
        @(negedge clk_sys);
      end
    end
    @(negedge clk_sys);
  endtask
endmodule

//--- verification/tape_ctrl_status_interrupt_tb.sv
// self-checking bench for the tape status and interrupt block
// assumes the host model owns the q/a channel; events are driven here
`timescale 1ns/10ps

module tape_ctrl_status_interrupt_tb;
  import tape_status_pkg::*;

  localparam logic [3:0] EQ = 4'h5;
  logic        clk_sys = 1'b0;
  logic        reset = 1'b1;
  logic [24:0] ev = '0;
  logic        ready = 1'b1, in_motion = 1'b0, ctrl_active = 1'b0, load_point = 1'b1;
  logic        write_enable = 1'b1, pe_formatter_in = 1'b1, low_threshold = 1'b1;
  logic        buffered_output = 1'b0, xfer_reg_full = 1'b0;
  logic [2:0]  density_sel = 3'b100, int_select = 3'b000;
  logic [1:0]  unit_num = 2'b01;
  logic [3:0]  equip_jumpers = EQ;
  logic [15:0] unit_jumpers = 16'hf068;
  logic [12:0] q_word;
  word_t       a_reply_q;
  logic        input_req, output_req, protected_instr, reply_q, reject_q;
  logic        stop_motion_q, end_record_q, stop_input_q, protect_to_host_q;
  logic        interrupt_q, high_speed_q, pe_only_q;
  logic        buffered_input_start, int_select_strobe, unit_select, clear_interrupt;
  logic        clear_controller, master_clear, new_motion, motion_from_loadpt;
  logic        id_burst_seen, pe_hard_error, bad_postamble, corrected_dropout;
  logic        host_protect_fault, host_parity_err, odd_words, wrong_mode, fmark_sensed;
  logic        eot_sensed, parity_evt, dsa_overrun, new_frame, end_of_record;
  logic        data_request, data_ready, motion_done;
  int          n_errors = 0;
  int          checked = 0;
  // event, bit, word two, alarm, cleared by new motion
  int          tbl [11][5] = '{'{7,9,0,1,1}, '{8,11,0,1,1}, '{6,8,0,1,1}, '{9,8,0,1,1},
    '{10,13,0,0,1}, '{11,14,0,1,1}, '{12,15,0,1,1}, '{13,5,1,1,1}, '{14,5,1,1,1},
    '{15,6,1,1,0}, '{5,6,0,1,1}};

  // one-cycle command and event strobes
  assign {buffered_input_start, int_select_strobe, unit_select, clear_interrupt,
          clear_controller, master_clear, new_motion, motion_from_loadpt, id_burst_seen,
          pe_hard_error, bad_postamble, corrected_dropout, host_protect_fault,
          host_parity_err, odd_words, wrong_mode, fmark_sensed, eot_sensed, parity_evt,
          dsa_overrun, new_frame, end_of_record, data_request, data_ready, motion_done} = ev;

  host_model u_host (.*);
  tape_ctrl_status_interrupt dut (.*);

  // 125 MHz clock
  always #4 clk_sys = ~clk_sys;

  ////////////////////////////////////////
  task automatic chk(input string n, input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", n, exp, got);
    end
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic pulse(input int i);
    ev <= 25'h1 << i;
    @(negedge clk_sys);
    ev <= '0;
  endtask

  task automatic rd(input logic [1:0] dir, output word_t w);
    logic [1:0] r;
    u_host.xfer(1'b0, 2'b00, EQ, dir, 1'b0, w, r);
    chk("reply", 16'(r), 16'h0001);
  endtask

  // bounded wait for an output level, timeout ends the run
  task automatic wt(input int s, input logic v, input string n);
    logic sig;
    for (int i = 0; i < 6; i++) begin
      sig = s == 0 ? interrupt_q : s == 1 ? stop_motion_q : s == 2 ? end_record_q : stop_input_q;
      if (sig === v) begin
        chk(n, 16'(sig), 16'(v));
        @(negedge clk_sys);
        return;
      end
      @(negedge clk_sys);
    end
    n_errors++;
    $display("[ERR] %s expected %b seen timeout", n, v);
    close_out();
  endtask

  ////////////////////////////////////////
  initial begin
    word_t w, w2;
    logic [1:0] d, r;
    repeat (5) @(negedge clk_sys);
    reset = 1'b0;
    @(negedge clk_sys);
    // straps of every unit in both words and on the strap outputs
    for (int u = 0; u < 4; u++) begin
      unit_num = 2'(u);
      repeat (2) @(negedge clk_sys);
      rd(2'b01, w);
      rd(2'b10, w2);
      if (u == 1) chk("word1", w, 16'h0401);
      if (u == 1) chk("word2", w2, 16'h0294);
      chk("protected", 16'(w[7]), 16'(unit_jumpers[4*u+3]));
      chk("seven", 16'(w2[3]), 16'(!unit_jumpers[4*u+1]));
      chk("speed", 16'(high_speed_q), 16'(unit_jumpers[4*u+2]));
      chk("pe_only", 16'(pe_only_q), 16'(unit_jumpers[4*u]));
    end
    // foreign equipment number or nonzero W
    for (int k = 0; k < 3; k++) begin
      u_host.xfer(1'b0, 2'(k), k == 0 ? ~EQ : EQ, 2'b01, 1'b0, w, r);
      chk("no_answer", 16'(r), 16'h0000);
    end
    // protected unit selected: plain output refused, protected accepted
    u_host.xfer(1'b1, 2'b00, EQ, 2'b00, 1'b0, w, r);
    chk("unprot_out", 16'(r), 16'h0002);
    u_host.xfer(1'b1, 2'b00, EQ, 2'b00, 1'b1, w, r);
    chk("prot_out", 16'(r), 16'h0001);
    unit_num = 2'b01;
    buffered_output = 1'b1;
    repeat (2) @(negedge clk_sys);
    // sticky flags with alarm, reread, then new motion
    for (int k = 0; k < 11; k++) begin
      d = tbl[k][2] ? 2'b10 : 2'b01;
      pulse(tbl[k][0]);
      if (tbl[k][0] == 5) wt(2, 1'b1, "end_record");
      rd(d, w);
      rd(d, w2);
      chk("reread", w2, w);
      chk("flag", 16'(w[tbl[k][1]]), 16'h0001);
      rd(2'b01, w);
      chk("alarm", 16'(w[5]), 16'(tbl[k][3]));
      pulse(18);
      rd(d, w);
      if (tbl[k][4]) chk("flag_clr", 16'(w[tbl[k][1]]), 16'h0000);
      rd(2'b01, w);
      chk("alarm_clr", 16'(w[5]), 16'h0000);
    end
    buffered_output = 1'b0;
    // data status and lost data on a full transfer register
    xfer_reg_full = 1'b1;
    pulse(1);
    rd(2'b01, w);
    chk("data_set", 16'(w[3]), 16'h0001);
    pulse(4);
    rd(2'b01, w);
    chk("lost", 16'({w[6], w[3]}), 16'h0002);
    xfer_reg_full = 1'b0;
    pulse(5);
    wt(3, 1'b1, "stop_input");
    pulse(18);
    for (int k = 2; k < 4; k++) begin
      @(negedge clk_sys);
      pulse(1);
      @(negedge clk_sys);
      pulse(k);
      rd(2'b01, w);
      chk("data_clr", 16'(w[3]), 16'h0000);
    end
    // clear controller drops alarm but keeps end of tape
    pulse(7);
    @(negedge clk_sys);
    pulse(20);
    rd(2'b01, w);
    chk("cc_alarm", 16'({w[9], w[5]}), 16'h0002);
    // end of operation set by motion done, cleared by master clear
    pulse(0);
    rd(2'b01, w);
    chk("eop", 16'(w[4]), 16'h0001);
    pulse(19);
    rd(2'b01, w);
    chk("eop_mc", 16'(w[4]), 16'h0000);
    // end of operation interrupt, then clear interrupt
    int_select = 3'b010;
    pulse(23);
    @(negedge clk_sys);
    pulse(0);
    wt(0, 1'b1, "int_eop");
    rd(2'b01, w);
    chk("int_bit", 16'(w[2]), 16'h0001);
    pulse(21);
    wt(0, 1'b0, "int_clr");
    // data interrupt cleared by transfer, then by reselect
    int_select = 3'b001;
    pulse(23);
    @(negedge clk_sys);
    pulse(1);
    wt(0, 1'b1, "int_data");
    pulse(2);
    wt(0, 1'b0, "int_xfer");
    pulse(1);
    wt(0, 1'b1, "int_data2");
    pulse(22);
    wt(0, 1'b0, "int_resel");
    // no id burst after leaving load point at 1600
    for (int k = 0; k < 2; k++) begin
      pulse(18);
      @(negedge clk_sys);
      pulse(17);
      @(negedge clk_sys);
      pulse(0);
      if (k == 0) wt(1, 1'b1, "stop");
      rd(2'b10, w);
      rd(2'b01, w2);
      chk("id_burst_abort", 16'({w[8], w2[5]}), k == 0 ? 16'h0003 : 16'h0000);
    end
    fork
      u_host.xfer(1'b1, 2'b00, EQ, 2'b11, 1'b1, w, r);
      pulse(24);
    join
    chk("prot_host", 16'(protect_to_host_q), 16'h0001);
    // busy, ready and controller active levels
    in_motion = 1'b1;
    ready = 1'b0;
    ctrl_active = 1'b1;
    @(negedge clk_sys);
    rd(2'b01, w);
    chk("levels", 16'({w[12], w[1], w[0]}), 16'h0006);
    close_out();
  end
endmodule
